// *** ft8_pkg.sv ***
// constants for the 8-bit down-counting timer with fine-adjust mode
// assumes a 16-bit register port addressed by the printed byte offsets
package ft8_pkg;

    // register port geometry
    localparam int ADDR_W = 16;                  // register address width
    localparam int DATA_W = 16;                  // register data width

    // register offsets
    localparam logic [15:0] OFF_CLK  = 16'h4200; // count_clock_divider_select
    localparam logic [15:0] OFF_TR   = 16'h4202; // timer_reload_value
    localparam logic [15:0] OFF_TC   = 16'h4204; // timer_count_readout
    localparam logic [15:0] OFF_CTL  = 16'h4206; // timer_control
    localparam logic [15:0] OFF_STAT = 16'h4208; // event status, write one to clear
    localparam logic [15:0] OFF_MASK = 16'h420a; // event mask

    // divider field codes
    localparam logic [3:0] DIV_UNDIV = 4'h0;     // undivided peripheral clock
    localparam logic [3:0] DIV_RSVD  = 4'hf;     // reserved, no count clock

    // prescaler taps: /2 up to /16384
    localparam int TAP_N = 14;

    // control register field positions
    localparam int CTL_RUN_BIT    = 0;           // run_stop_bit
    localparam int CTL_REINIT_BIT = 1;           // counter_reinit_bit, write-only
    localparam int CTL_MODE_BIT   = 4;           // oneshot_repeat_select
    localparam int CTL_FINE_LSB   = 8;           // fine_delay_count low bit
    localparam int CTL_FINE_MSB   = 11;          // fine_delay_count high bit

    // status and mask layout
    localparam int STAT_W       = 2;
    localparam int STAT_UF_BIT  = 0;             // counter underflow
    localparam int STAT_OS_BIT  = 1;             // one-shot run finished

    // reset values
    localparam logic [3:0] RST_DIV    = 4'h0;
    localparam logic [7:0] RST_RELOAD = 8'h00;
    localparam logic [7:0] RST_COUNT  = 8'hff;
    localparam logic [3:0] RST_FINE   = 4'h0;
    localparam logic [STAT_W-1:0] RST_STAT = 2'h0;
    localparam logic [STAT_W-1:0] RST_MASK = 2'h0;

    // fine mode spreads its delays over this many underflows
    localparam int FINE_WINDOW = 16;

endpackage : ft8_pkg

// *** ft8_timer.sv ***
// 8-bit down-counting timer with fine-adjust mode, register port and event interrupt
// assumes the prescaler taps come from logic on mclk (no synchronisers) and that
// the register master follows the one-cycle strobe protocol with read data a cycle later
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns

module ft8_timer
    import ft8_pkg::*;
#(
    parameter int TAPS = ft8_pkg::TAP_N      // number of divided prescaler taps
) (
    input  wire logic                      mclk,        // peripheral clock, 20 MHz
    input  wire logic                      rst_b,       // asynchronous reset, active low
    input  wire logic [ft8_pkg::ADDR_W-1:0] bus_addr,   // register address
    input  wire logic [ft8_pkg::DATA_W-1:0] bus_wdata,  // register write data
    input  wire logic                      bus_wr,      // write strobe
    input  wire logic                      bus_rd,      // read strobe
    output logic      [ft8_pkg::DATA_W-1:0] bus_rdata,  // read data, cycle after strobe
    input  wire logic [TAPS-1:0]           psc_tap,     // prescaler outputs /2 .. /16384
    output logic                           timer_uf,    // underflow pulse
    output logic                           irq          // level interrupt
);
    import ft8_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // reset release

    logic [1:0] rst_sync_q;                  // two-stage release of rst_b
    logic       rst_n;                       // synchronised reset, active low

    // release through two flops so no flop leaves reset on a ragged edge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [3:0]        code_q;               // clock_divider_code
    logic [7:0]        reload_q;             // reload_value
    logic [7:0]        count_q;              // count_value
    logic [3:0]        fine_q;               // fine_delay_count
    logic              oneshot_q;            // oneshot_repeat_select
    logic              run_q;                // run_stop_bit
    logic [3:0]        win_q;                // underflow index inside the window
    logic              pend_q;               // delay tick in progress
    logic              tap_prev_q;           // selected tap, last cycle
    logic [STAT_W-1:0] stat_q;               // sticky events
    logic [STAT_W-1:0] mask_q;               // event mask
    logic [DATA_W-1:0] rdata_q;              // read data register
    logic              uf_q;                 // underflow pulse register

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    wire sel_clk  = (bus_addr == OFF_CLK);   // divider select
    wire sel_tr   = (bus_addr == OFF_TR);    // reload value
    wire sel_tc   = (bus_addr == OFF_TC);    // count readout
    wire sel_ctl  = (bus_addr == OFF_CTL);   // control
    wire sel_stat = (bus_addr == OFF_STAT);  // status
    wire sel_mask = (bus_addr == OFF_MASK);  // mask

    wire wr_clk   = bus_wr & sel_clk;
    wire wr_tr    = bus_wr & sel_tr;
    wire wr_ctl   = bus_wr & sel_ctl;
    wire wr_stat  = bus_wr & sel_stat;
    wire wr_mask  = bus_wr & sel_mask;

    // a one written to the reinit bit restarts the counter; a zero does nothing
    wire reinit   = wr_ctl & bus_wdata[CTL_REINIT_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // count clock selection

    // tap vector indexed directly by the code: slot 0 and slot 15 unused
    wire [15:0] tap_ext = {1'b0, psc_tap, 1'b0};
    wire        tap_cur = tap_ext[code_q];
    wire        tap_rise = tap_cur & ~tap_prev_q;

    // code 0 ticks every cycle, reserved code never ticks
    wire tick = (code_q == DIV_UNDIV) ? 1'b1 :
                (code_q == DIV_RSVD)  ? 1'b0 : tap_rise;

    // changing the code may show one spurious edge; software changes it while stopped
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tap_prev_q <= 1'b0;
        end else begin
            tap_prev_q <= tap_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counting and fine mode

    wire       step    = run_q & tick;
    wire       at_zero = (count_q == 8'h00);
    // bit-reversed index gives an even spread of the delayed underflows
    wire [3:0] win_rev = {win_q[0], win_q[1], win_q[2], win_q[3]};
    wire       need_dly = (win_rev < fine_q);
    // the delayed underflow holds at zero for one extra count tick
    wire       hold    = step & at_zero & need_dly & ~pend_q;
    wire       uflow   = step & at_zero & ~hold;
    wire       os_done = uflow & oneshot_q;

    wire [7:0] count_d = reinit             ? reload_q :
                         uflow              ? reload_q :
                         (step & ~at_zero)  ? count_q - 8'h01 :
                         count_q;
    wire       pend_d  = reinit ? 1'b0 : hold ? 1'b1 : uflow ? 1'b0 : pend_q;
    wire [3:0] win_d   = reinit ? 4'h0 : uflow ? win_q + 4'h1 : win_q;
    // a software write to control wins over the one-shot stop
    wire       run_d   = wr_ctl  ? bus_wdata[CTL_RUN_BIT] :
                         os_done ? 1'b0 : run_q;

    // counter, window index and delay flag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= RST_COUNT;
            pend_q  <= 1'b0;
            win_q   <= 4'h0;
            run_q   <= 1'b0;
            uf_q    <= 1'b0;
        end else begin
            count_q <= count_d;
            pend_q  <= pend_d;
            win_q   <= win_d;
            run_q   <= run_d;
            uf_q    <= uflow;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software-written configuration

    // divider code
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= RST_DIV;
        end else if (wr_clk) begin
            code_q <= bus_wdata[3:0];
        end
    end

    // reload value, low byte only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reload_q <= RST_RELOAD;
        end else if (wr_tr) begin
            reload_q <= bus_wdata[7:0];
        end
    end

    // control fields other than run
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fine_q    <= RST_FINE;
            oneshot_q <= 1'b0;
        end else if (wr_ctl) begin
            fine_q    <= bus_wdata[CTL_FINE_MSB:CTL_FINE_LSB];
            oneshot_q <= bus_wdata[CTL_MODE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // events and interrupt

    wire [STAT_W-1:0] evt   = {os_done, uflow};
    wire [STAT_W-1:0] w1c   = wr_stat ? bus_wdata[STAT_W-1:0] : {STAT_W{1'b0}};
    // an event in the clearing cycle survives: set wins over clear
    wire [STAT_W-1:0] stat_d = (stat_q & ~w1c) | evt;

    // sticky status and mask
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= RST_STAT;
            mask_q <= RST_MASK;
        end else begin
            stat_q <= stat_d;
            if (wr_mask) begin
                mask_q <= bus_wdata[STAT_W-1:0];
            end
        end
    end

    assign irq      = |(stat_q & mask_q);
    assign timer_uf = uf_q;

    ////////////////////////////////////////////////////////////////////////////
    // read path

    wire [DATA_W-1:0] rd_clk  = {12'h000, code_q};
    wire [DATA_W-1:0] rd_tr   = {8'h00, reload_q};
    wire [DATA_W-1:0] rd_tc   = {8'h00, count_q};
    // reinit bit is write-only and reads as zero
    wire [DATA_W-1:0] rd_ctl  = {4'h0, fine_q, 3'h0, oneshot_q, 3'h0, run_q};
    wire [DATA_W-1:0] rd_stat = {14'h0000, stat_q};
    wire [DATA_W-1:0] rd_mask = {14'h0000, mask_q};
    // unmapped addresses read as zero
    wire [DATA_W-1:0] rd_mux  = sel_clk  ? rd_clk  :
                                sel_tr   ? rd_tr   :
                                sel_tc   ? rd_tc   :
                                sel_ctl  ? rd_ctl  :
                                sel_stat ? rd_stat :
                                sel_mask ? rd_mask : 16'h0000;

    // data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= bus_rd ? rd_mux : 16'h0000;
        end
    end
    assign bus_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_rsvd_no_tick;
        (code_q == DIV_RSVD) |-> !tick;
    endproperty
    a_rsvd_no_tick: assert property (p_rsvd_no_tick)
        else $error("reserved divider code produced a tick");

    property p_undiv_ticks;
        (code_q == DIV_UNDIV) && run_q && !at_zero && !reinit
            |=> count_q == $past(count_q) - 8'h01;
    endproperty
    a_undiv_ticks: assert property (p_undiv_ticks)
        else $error("undivided clock did not step the counter every cycle");

    property p_tap_edge;
        $stable(code_q) && (code_q != DIV_UNDIV) && tick
            |-> tap_ext[code_q] && !$past(tap_ext[code_q]);
    endproperty
    a_tap_edge: assert property (p_tap_edge)
        else $error("tick not on a rising edge of the selected tap");

    property p_reload_read;
        bus_rd && sel_tr |=> bus_rdata == {8'h00, $past(reload_q)};
    endproperty
    a_reload_read: assert property (p_reload_read)
        else $error("reload readback wrong or upper byte not zero");

    property p_reinit;
        reinit |=> count_q == $past(reload_q) && !pend_q && win_q == 4'h0;
    endproperty
    a_reinit: assert property (p_reinit)
        else $error("reinit did not load the reload value");

    property p_count_read;
        bus_rd && sel_tc |=> bus_rdata == {8'h00, $past(count_q)};
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("count readback wrong");

    property p_fine_read;
        bus_rd && sel_ctl |=> bus_rdata[11:8] == $past(fine_q) && !bus_rdata[1];
    endproperty
    a_fine_read: assert property (p_fine_read)
        else $error("fine field readback wrong");

    property p_fine_zero;
        (fine_q == 4'h0) && !pend_q && step && at_zero |-> uflow;
    endproperty
    a_fine_zero: assert property (p_fine_zero)
        else $error("delay inserted with fine count zero");

    property p_delay_then_uf;
        hold && !reinit |=> pend_q && count_q == 8'h00;
    endproperty
    a_delay_then_uf: assert property (p_delay_then_uf)
        else $error("delayed underflow did not hold at zero");

    property p_stopped;
        !run_q && !reinit |=> $stable(count_q);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("counter moved while stopped");

    property p_oneshot_stop;
        uflow && oneshot_q && !wr_ctl |=> !run_q ##1 (!run_q || $past(wr_ctl));
    endproperty
    a_oneshot_stop: assert property (p_oneshot_stop)
        else $error("one-shot did not stop after underflow");

    property p_uf_reload;
        uflow && !reinit |=> count_q == $past(reload_q) && timer_uf && stat_q[STAT_UF_BIT];
    endproperty
    a_uf_reload: assert property (p_uf_reload)
        else $error("underflow did not reload and flag");

    // software writes land at the edge that takes the strobe
    property p_clk_write;
        wr_clk |=> code_q == $past(bus_wdata[3:0]);
    endproperty
    a_clk_write: assert property (p_clk_write)
        else $error("divider code write did not land");

    property p_reload_write;
        wr_tr |=> reload_q == $past(bus_wdata[7:0]);
    endproperty
    a_reload_write: assert property (p_reload_write)
        else $error("reload write did not land");

    // a zero in the reinit bit must leave the count alone
    property p_reinit_zero;
        wr_ctl && !bus_wdata[CTL_REINIT_BIT] && !step |=> count_q == $past(count_q);
    endproperty
    a_reinit_zero: assert property (p_reinit_zero)
        else $error("control write without reinit moved the count");

    property p_fine_write;
        wr_ctl |=> fine_q == $past(bus_wdata[CTL_FINE_MSB:CTL_FINE_LSB]);
    endproperty
    a_fine_write: assert property (p_fine_write)
        else $error("fine field write did not land");

    // the window index advances once per real underflow and wraps at sixteen
    property p_win_step;
        uflow && !reinit |=> win_q == $past(win_q) + 4'h1;
    endproperty
    a_win_step: assert property (p_win_step)
        else $error("window index did not advance on underflow");

    property p_os_flag;
        os_done |=> stat_q[STAT_OS_BIT];
    endproperty
    a_os_flag: assert property (p_os_flag)
        else $error("one-shot finish not flagged");

    c_oneshot_done: cover property (os_done ##1 !run_q);
    c_reinit:       cover property (reinit ##1 count_q == reload_q);
    c_fine_hold:    cover property (hold ##[1:20] uflow);
    c_irq:          cover property (!irq ##1 irq);
    c_repeat:       cover property (uflow && !oneshot_q ##[1:600] uflow);

endmodule : ft8_timer

// *** ft8_psc_model.sv ***
// model of the shared clock prescaler that feeds the timer's count clock taps
// assumes it runs on the same mclk and reset as the timer under test
`timescale 1ns/1ns

module ft8_psc_model #(
    parameter int TAPS = 14                  // number of divided outputs
) (
    input  wire logic            mclk,       // peripheral clock
    input  wire logic            rst_b,      // reset, active low
    output logic      [TAPS-1:0] psc_tap     // tap i divides mclk by 2^(i+1)
);

    ////////////////////////////////////////////////////////////////////////
    logic [TAPS-1:0] div_q;                  // free-running divider chain

    // the chain runs free, as a shared prescaler does; the timer only
    // looks for rising edges of the tap it selects
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= '0;                     // all taps low in reset
        end else begin
            div_q <= div_q + 1'h1;           // one step per peripheral clock
        end
    end

    // each bit of the chain is a square wave at half the rate of the one below
    assign psc_tap = div_q;

endmodule : ft8_psc_model

// *** tb.sv ***
// self-checking bench for the fine-mode 8-bit timer
// assumes the timer package and the prescaler model are compiled first
`timescale 1ns/1ns

module tb;
    import ft8_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic        mclk, rst_b, bus_wr, bus_rd, timer_uf, irq;
    logic [15:0] bus_addr, bus_wdata, bus_rdata;
    logic [13:0] psc_tap;                    // taps from the prescaler model
    int          fails, cmp_count, n, tot;   // counters and measured spans
    logic [3:0]  fv [3] = '{4'h1, 4'h4, 4'hf};  // fine settings tried
    int          dv [3] = '{1, 3, 14};          // divider codes tried

    ft8_timer ft8_timer_inst (.mclk(mclk), .rst_b(rst_b), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .psc_tap(psc_tap), .timer_uf(timer_uf), .irq(irq));
    ft8_psc_model ft8_psc_model_inst (.mclk(mclk), .rst_b(rst_b), .psc_tap(psc_tap));

    // 20 MHz clock
    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("counts: %0d mismatches in %0d compares", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp16

    task automatic cmp_n(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_n

    // one-cycle write strobe, released at the edge that takes it
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'h1;
        @(posedge mclk);
        bus_wr    <= 1'h0;
    endtask : wr

    // read data stands only in the cycle after the strobe, so look there
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd   <= 1'h1;
        @(posedge mclk);
        bus_rd   <= 1'h0;
        #1 cmp16(bus_rdata, exp);
    endtask : rd

    // cycles until the next underflow pulse, bounded so a dead timer fails
    task automatic wait_uf(output int cnt);
        cnt = 0;
        do begin
            @(posedge mclk);
            #1 cnt++;
        end while (timer_uf !== 1'h1 && cnt < 20000);
        if (cnt >= 20000) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, cnt, 20000);
        end
    endtask : wait_uf

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(OFF_CLK, 16'h0000);
        rd(OFF_TR, 16'h0000);
        rd(OFF_TC, 16'h00ff);
        rd(OFF_CTL, 16'h0000);
        rd(OFF_STAT, 16'h0000);
        rd(OFF_MASK, 16'h0000);
        rd(16'h420c, 16'h0000);
        $display("test reset values done");
    endtask : t_reset

    task automatic t_regs;
        wr(OFF_TR, 16'hffa5);
        rd(OFF_TR, 16'h00a5);
        wr(OFF_CTL, 16'h0f12);
        rd(OFF_CTL, 16'h0f10);
        rd(OFF_TC, 16'h00a5);
        wr(OFF_TR, 16'h0010);
        wr(OFF_CTL, 16'h0000);
        rd(OFF_TC, 16'h00a5);
        wr(OFF_CLK, 16'hfff3);
        rd(OFF_CLK, 16'h0003);
        wr(16'h420c, 16'hffff);
        rd(16'h420c, 16'h0000);
        wr(OFF_CLK, 16'h0000);
        $display("test register access done");
    endtask : t_regs

    task automatic t_oneshot;
        wr(OFF_TR, 16'h0002);
        wr(OFF_MASK, 16'h0003);
        wr(OFF_CTL, 16'h0013);
        wait_uf(n);
        cmp_n(n, 3);
        rd(OFF_TC, 16'h0002);
        rd(OFF_CTL, 16'h0010);
        rd(OFF_STAT, 16'h0003);
        cmp16({15'h0, irq}, 16'h0001);
        wr(OFF_STAT, 16'h0003);
        rd(OFF_STAT, 16'h0000);
        cmp16({15'h0, irq}, 16'h0000);
        $display("test one-shot done");
    endtask : t_oneshot

    task automatic t_repeat;
        // underflow event masked, so the level output must stay low
        wr(OFF_MASK, 16'h0002);
        wr(OFF_TR, 16'h0003);
        wr(OFF_CTL, 16'h0003);
        wait_uf(n);
        wait_uf(n);
        cmp_n(n, 4);
        wait_uf(n);
        cmp_n(n, 4);
        cmp16({15'h0, irq}, 16'h0000);
        rd(OFF_STAT, 16'h0001);
        wr(OFF_CTL, 16'h0002);
        repeat (10) @(posedge mclk);
        rd(OFF_TC, 16'h0003);
        wr(OFF_STAT, 16'h0003);
        $display("test repeat and stop done");
    endtask : t_repeat

    task automatic t_fine;
        // any sixteen underflows in a row carry exactly fine extra ticks
        for (int i = 0; i < 3; i++) begin
            wr(OFF_CTL, {4'h0, fv[i], 8'h03});
            wait_uf(n);
            tot = 0;
            repeat (16) begin
                wait_uf(n);
                tot += n;
            end
            cmp_n(tot, 64 + int'(fv[i]));
            wr(OFF_CTL, 16'h0000);
        end
        $display("test fine mode done");
    endtask : t_fine

    task automatic t_div;
        // reload zero makes every count tick an underflow
        wr(OFF_TR, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            wr(OFF_CLK, 16'(dv[i]));
            wr(OFF_CTL, 16'h0003);
            wait_uf(n);
            wait_uf(n);
            cmp_n(n, 1 << dv[i]);
            wr(OFF_CTL, 16'h0000);
        end
        wr(OFF_CLK, 16'h000f);
        wr(OFF_STAT, 16'h0003);
        wr(OFF_CTL, 16'h0003);
        repeat (40) @(posedge mclk);
        rd(OFF_STAT, 16'h0000);
        wr(OFF_CTL, 16'h0000);
        $display("test divider codes done");
    endtask : t_div

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_b     = 1'h0;
        bus_wr    = 1'h0;
        bus_rd    = 1'h0;
        bus_addr  = 16'h0000;
        bus_wdata = 16'h0000;
        fails     = 0;
        cmp_count = 0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'h1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_regs();
        t_oneshot();
        t_repeat();
        t_fine();
        t_div();
        end_sim();
    end

    // watchdog well beyond the longest expected run
    initial begin
        #(50 * 80000);
        fails++;
        end_sim();
    end

endmodule : tb
